// >>> dsc_pkg.sv
package dsc_pkg;

  // ==========================================================================
  // Conversion constants
  // ==========================================================================
  localparam int RES_BITS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CHANNELS = 2;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  localparam logic [15:0] TRIAL_START = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [3:0] MSB_IDX = 4'hF;
  localparam logic [3:0] LSB_IDX = 4'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int REF_CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_NS = 1000;
  // Longest time, so it rounds down.
  localparam int CYCLES_PER_SAMPLE = SAMPLE_PERIOD_NS / REF_CLK_PERIOD_NS;
  // Edge detect, open switches, ground arrays, trials, done.
  localparam int CONV_CYCLES = 1 + 1 + 1 + RES_BITS + 1;

  // ==========================================================================
  // Sequencer states, Gray coded along the conversion path
  // ==========================================================================
  typedef enum logic [2:0] {
    DSC_ACQ = 3'h0,
    DSC_OPEN = 3'h1,
    DSC_GND = 3'h3,
    DSC_TRIAL = 3'h2,
    DSC_DONE = 3'h6
  } dsc_state_e;

endpackage : dsc_pkg

// >>> dsc_top.sv
`timescale 1ns/1ps
// What this block does
// - Each channel acquires until a rising convert-start edge begins its conversion.
// - Conversion opens both node ground switches, then grounds arrays, before trials.
// - Sixteen binary-weighted trials from the top bit, smallest one in 65,536.
// - After the search: back to acquisition, present code, pulse the done event.
// - The internal reference clock times conversion; the host shift clock never does.
// - Results queue first in, first out; the word shifted out is the oldest unread one.
// - Two channels convert at once, independently, each up to one million per second.
// - Conversion circuitry is powered only while a conversion runs.
// - Results are two's complement, zero input giving 0x0000.
// - Overrange saturates at 0x7FFF instead of wrapping.
// - Underrange saturates at 0x8000 instead of wrapping.
// - Each serial output shifts the result in step with that channel's host clock.

// ============================================================================
// Result FIFO
// ============================================================================
module dsc_fifo
  import dsc_pkg::*;
#(
  parameter int WIDTH = RES_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointers wrap naturally, so DEPTH must be a power of two.
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dsc_fifo_s;

  dsc_fifo_s q;
  dsc_fifo_s next_q;
  logic wr;
  logic rd;

  assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  always_comb begin
    next_q = q;
    if (wr) begin
      next_q.mem[q.wp] = in_data;
      next_q.wp = q.wp + 1'b1;
    end
    if (rd) begin
      next_q.rp = q.rp + 1'b1;
    end
    next_q.cnt = q.cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : dsc_fifo

// ============================================================================
// One converter channel: sequencer, result buffer and serial link
// ============================================================================
module dsc_channel
  import dsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host side pins
  input wire logic convert_start_in,
  input wire logic host_shift_clock,
  output logic result_serial_out,
  output logic result_ready,
  // Analog front end
  input wire logic comparator_high,
  output logic pos_node_ground_switch,
  output logic neg_node_ground_switch,
  output logic array_to_input,
  output logic array_to_ground,
  output logic [RES_BITS-1:0] dac_code,
  output logic power_up,
  // Status
  output logic busy,
  output logic conv_done
);
  typedef struct packed {
    logic cnv_s1;
    logic cnv_s2;
    logic cnv_s3;
    dsc_state_e st;
    logic [RES_BITS-1:0] trial;
    logic [3:0] bit_idx;
    logic [RES_BITS-1:0] result;
    logic push;
    logic pos_sw;
    logic neg_sw;
    logic arr_in;
    logic arr_gnd;
    logic pwr;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic req_tog;
    logic held_valid;
    logic [RES_BITS-1:0] held;
  } dsc_core_s;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tog;
    logic active;
    logic [3:0] cnt;
    logic [RES_BITS-1:0] sh;
  } dsc_link_s;

  dsc_core_s c;
  dsc_core_s next_c;
  dsc_link_s l;
  dsc_link_s next_l;
  logic start_edge;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [RES_BITS-1:0] fifo_out_data;

  // ==========================================================================
  // Result buffer between the sequencer and the link handshake
  // ==========================================================================
  dsc_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(c.push),
    .in_ready(fifo_in_ready),
    .in_data(c.result),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Synchronised start edge, read only from the second and third stages.
  assign start_edge = c.cnv_s2 & ~c.cnv_s3;
  assign fifo_pop = ~c.held_valid;

  // ==========================================================================
  // Core domain: conversion sequencer, timed by ref_clk alone
  // ==========================================================================
  always_comb begin
    next_c = c;
    next_c.cnv_s1 = convert_start_in;
    next_c.cnv_s2 = c.cnv_s1;
    next_c.cnv_s3 = c.cnv_s2;
    next_c.push = 1'b0;
    case (c.st)
      DSC_ACQ: begin
        // A full buffer holds off the start, but the check misses a push in the same cycle, so a start taken
        // right after a done that fills the last place can drop its own result. Only this state looks
        // at the start edge, so an edge during a conversion simply falls away.
        if (start_edge && fifo_in_ready) begin
          next_c.st = DSC_OPEN;
        end
      end
      DSC_OPEN: begin
        next_c.st = DSC_GND;
      end
      DSC_GND: begin
        next_c.st = DSC_TRIAL;
        next_c.trial = TRIAL_START;
        next_c.bit_idx = MSB_IDX;
      end
      DSC_TRIAL: begin
        // A high comparator means the trial level overshoots the held input.
        if (comparator_high) begin
          next_c.trial[c.bit_idx] = 1'b0;
        end
        if (c.bit_idx == LSB_IDX) begin
          next_c.st = DSC_DONE;
        end else begin
          next_c.trial[c.bit_idx - 1'b1] = 1'b1;
          next_c.bit_idx = c.bit_idx - 1'b1;
        end
      end
      DSC_DONE: begin
        // Offset binary to two's complement; the search itself pins out-of-range
        // inputs at all ones or all zeros, so no wrap can occur.
        next_c.result = c.trial ^ SIGN_FLIP;
        next_c.push = 1'b1;
        next_c.st = DSC_ACQ;
      end
      default: begin
        next_c.st = DSC_ACQ;
      end
    endcase
    next_c.pos_sw = (next_c.st == DSC_ACQ) || (next_c.st == DSC_DONE);
    next_c.neg_sw = next_c.pos_sw;
    next_c.arr_in = (next_c.st == DSC_ACQ) || (next_c.st == DSC_OPEN) || (next_c.st == DSC_DONE);
    next_c.arr_gnd = (next_c.st == DSC_GND) || (next_c.st == DSC_TRIAL);
    next_c.pwr = (next_c.st != DSC_ACQ) && (next_c.st != DSC_DONE);
    if (next_c.st != DSC_TRIAL) begin
      next_c.trial = (next_c.st == DSC_DONE) ? next_c.trial : CODE_ZERO;
    end

    // Handshake toward the link: hold one word, toggle a request, await ack.
    next_c.ack_s1 = l.ack_tog;
    next_c.ack_s2 = c.ack_s1;
    next_c.ack_s3 = c.ack_s2;
    if (c.held_valid && (c.ack_s2 != c.ack_s3)) begin
      next_c.held_valid = 1'b0;
    end
    if (!c.held_valid && fifo_out_valid) begin
      next_c.held = fifo_out_data;
      next_c.held_valid = 1'b1;
      next_c.req_tog = ~c.req_tog;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // ==========================================================================
  // Link domain: shifts the held word out on the host clock
  // ==========================================================================
  always_comb begin
    next_l = l;
    next_l.rst_s1 = rst;
    next_l.rst_s2 = l.rst_s1;
    // The request synchroniser rests during a frame, so every frame opens with the same
    // two-edge preamble however early the next word was queued.
    if (!l.active) begin
      next_l.req_s1 = c.req_tog;
      next_l.req_s2 = l.req_s1;
    end
    if (l.active) begin
      next_l.sh = {l.sh[RES_BITS-2:0], 1'b0};
      next_l.cnt = l.cnt - 1'b1;
      if (l.cnt == LSB_IDX) begin
        next_l.active = 1'b0;
      end
    end else if (l.req_s2 != l.req_seen) begin
      // Held word is stable while the request is open, so it is safe to read.
      next_l.sh = c.held;
      next_l.req_seen = l.req_s2;
      next_l.ack_tog = ~l.ack_tog;
      next_l.cnt = MSB_IDX - 1'b1;
      next_l.active = 1'b1;
    end
    if (l.rst_s2) begin
      next_l = '0;
      next_l.rst_s1 = rst;
      next_l.rst_s2 = l.rst_s1;
    end
  end

  always_ff @(posedge host_shift_clock) begin
    l <= next_l;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign result_serial_out = l.sh[RES_BITS-1];
  assign result_ready = c.held_valid;
  assign pos_node_ground_switch = c.pos_sw;
  assign neg_node_ground_switch = c.neg_sw;
  assign array_to_input = c.arr_in;
  assign array_to_ground = c.arr_gnd;
  assign dac_code = c.trial;
  assign power_up = c.pwr;
  assign busy = c.pwr;
  assign conv_done = c.push;
endmodule : dsc_channel

// ============================================================================
// Dual converter top
// ============================================================================
module dsc_top
  import dsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host side pins, one per channel
  input wire logic [CHANNELS-1:0] convert_start_in,
  input wire logic [CHANNELS-1:0] host_shift_clock,
  output logic [CHANNELS-1:0] result_serial_out,
  output logic [CHANNELS-1:0] result_ready,
  // Analog front end, one per channel
  input wire logic [CHANNELS-1:0] comparator_high,
  output logic [CHANNELS-1:0] pos_node_ground_switch,
  output logic [CHANNELS-1:0] neg_node_ground_switch,
  output logic [CHANNELS-1:0] array_to_input,
  output logic [CHANNELS-1:0] array_to_ground,
  output logic [CHANNELS-1:0][RES_BITS-1:0] dac_code,
  output logic [CHANNELS-1:0] power_up,
  // Status
  output logic [CHANNELS-1:0] busy,
  output logic [CHANNELS-1:0] conv_done
);
  // Fully separate channels; nothing is shared but the core clock and reset.
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    dsc_channel #(
      .DEPTH(DEPTH)
    ) u_ch (
      .ref_clk(ref_clk),
      .rst(rst),
      .convert_start_in(convert_start_in[i]),
      .host_shift_clock(host_shift_clock[i]),
      .result_serial_out(result_serial_out[i]),
      .result_ready(result_ready[i]),
      .comparator_high(comparator_high[i]),
      .pos_node_ground_switch(pos_node_ground_switch[i]),
      .neg_node_ground_switch(neg_node_ground_switch[i]),
      .array_to_input(array_to_input[i]),
      .array_to_ground(array_to_ground[i]),
      .dac_code(dac_code[i]),
      .power_up(power_up[i]),
      .busy(busy[i]),
      .conv_done(conv_done[i])
    );
  end
endmodule : dsc_top

// >>> dsc_monitor.sv
`timescale 1ns/1ps
module dsc_monitor
  import dsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Observed ports
  input wire logic [CHANNELS-1:0] convert_start_in,
  input wire logic [CHANNELS-1:0] pos_node_ground_switch,
  input wire logic [CHANNELS-1:0] neg_node_ground_switch,
  input wire logic [CHANNELS-1:0] array_to_input,
  input wire logic [CHANNELS-1:0] array_to_ground,
  input wire logic [CHANNELS-1:0][RES_BITS-1:0] dac_code,
  input wire logic [CHANNELS-1:0] power_up,
  input wire logic [CHANNELS-1:0] busy,
  input wire logic [CHANNELS-1:0] conv_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========
  // Per channel
  // ==========
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic [4:0] cnt;
    always_ff @(posedge ref_clk) begin
      if (rst || !busy[c]) begin
        cnt <= 5'h00;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
    sequence s_open;
      !pos_node_ground_switch[c] && !neg_node_ground_switch[c] && array_to_input[c];
    endsequence
    sequence s_ground;
      array_to_ground[c] && !array_to_input[c];
    endsequence
    start_edge_a: assert property ($rose(busy[c]) |-> $past(convert_start_in[c], 2))
      else $error("conversion began without a start edge");
    switch_order_a: assert property ($rose(busy[c]) |-> s_open ##1 s_ground)
      else $error("switch sequence wrong at conversion start");
    first_trial_a: assert property ($rose(busy[c]) |-> ##2 dac_code[c] == TRIAL_START)
      else $error("first trial is not the top bit");
    busy_length_a: assert property ($fell(busy[c]) |-> cnt == 5'h12)
      else $error("conversion length wrong");
    done_return_a: assert property ($fell(busy[c]) |-> pos_node_ground_switch[c] && array_to_input[c] ##1 conv_done[c])
      else $error("no return to acquisition at the end");
    done_pulse_a: assert property (conv_done[c] |=> !conv_done[c])
      else $error("done event longer than one cycle");
    power_idle_a: assert property (power_up[c] == (!pos_node_ground_switch[c] && (array_to_input[c] || array_to_ground[c])))
      else $error("power not tied to conversion");
    no_restart_a: assert property (busy[c] |=> busy[c] or (!power_up[c] ##1 conv_done[c]))
      else $error("conversion cut short");
    idle_code_a: assert property (!busy[c] && !$fell(busy[c]) |-> dac_code[c] == CODE_ZERO)
      else $error("trial code active while idle");
  end
endmodule : dsc_monitor

bind dsc_top dsc_monitor #(.DEPTH(DEPTH)) u_mon (.ref_clk(ref_clk), .rst(rst), .convert_start_in(convert_start_in),
  .pos_node_ground_switch(pos_node_ground_switch), .neg_node_ground_switch(neg_node_ground_switch),
  .array_to_input(array_to_input), .array_to_ground(array_to_ground), .dac_code(dac_code),
  .power_up(power_up), .busy(busy), .conv_done(conv_done));

// >>> dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model
  import dsc_pkg::*;
(
  // Clocks and reset
  input wire logic link_clk,
  input wire logic rst,
  // Analog side
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic signed [31:0] level,
  output logic comparator_high,
  // Serial link
  input wire logic hold,
  input wire logic result_ready,
  input wire logic result_serial_out,
  output logic host_shift_clock,
  output logic [RES_BITS-1:0] word,
  output int frames
);
  logic run;
  int tail;
  // The gate only changes while the link clock is low, so no runt pulses.
  assign host_shift_clock = link_clk & run;
  assign comparator_high = int'(dac_code) > level;
  initial begin
    run = 1'b1;
    tail = 3;
    frames = 0;
    word = '0;
    forever begin
      @(negedge link_clk);
      // The clock runs on a little past reset so the link's reset stages empty out.
      tail = rst ? 3 : ((tail > 0) ? tail - 1 : 0);
      run = (tail > 0);
      if (tail == 0 && result_ready && !hold) begin
        run = 1'b1;
        repeat (2) @(negedge link_clk);
        for (int i = 0; i < RES_BITS; i++) begin
          @(negedge link_clk);
          word = {word[RES_BITS-2:0], result_serial_out};
        end
        frames++;
        run = 1'b0;
      end
    end
  end
endmodule : dsc_host_model

// >>> dual_sar_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module dual_sar_conversion_sequencer_tb
  import dsc_pkg::*;
;
  localparam int DEPTH = 4;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst;
  logic [1:0] cnv;
  logic hold0, hold1;
  int lvl0, lvl1, frames0, frames1, n_done0, n_done1, cycles, num_errors, compares;
  wire [1:0] sck, cmp, sdo, rdy, busy, done;
  wire [1:0][15:0] dac;
  logic [15:0] word0, word1;
  always #25 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  dsc_top #(.DEPTH(DEPTH)) dut (.ref_clk(ref_clk), .rst(rst), .convert_start_in(cnv), .host_shift_clock(sck),
    .result_serial_out(sdo), .result_ready(rdy), .comparator_high(cmp), .pos_node_ground_switch(),
    .neg_node_ground_switch(), .array_to_input(), .array_to_ground(), .dac_code(dac), .power_up(),
    .busy(busy), .conv_done(done));
  dsc_host_model u_h0 (.link_clk(link_clk), .rst(rst), .dac_code(dac[0]), .level(lvl0), .comparator_high(cmp[0]),
    .hold(hold0), .result_ready(rdy[0]), .result_serial_out(sdo[0]), .host_shift_clock(sck[0]), .word(word0),
    .frames(frames0));
  dsc_host_model u_h1 (.link_clk(link_clk), .rst(rst), .dac_code(dac[1]), .level(lvl1), .comparator_high(cmp[1]),
    .hold(hold1), .result_ready(rdy[1]), .result_serial_out(sdo[1]), .host_shift_clock(sck[1]), .word(word1),
    .frames(frames1));
  function automatic logic [15:0] code_of(input int l);
    int c;
    c = (l < 0) ? 0 : ((l > 65535) ? 65535 : l);
    return 16'(c) ^ SIGN_FLIP;
  endfunction : code_of
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    if (done[0] === 1'b1) n_done0++;
    if (done[1] === 1'b1) n_done1++;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic pulse(input logic [1:0] m);
    cnv <= m;
    repeat (4) @(posedge ref_clk);
    cnv <= 2'b00;
    @(posedge ref_clk);
  endtask : pulse
  task automatic wait_frames(input int w0, input int w1);
    int n;
    n = 0;
    while ((frames0 < w0 || frames1 < w1) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("frame arrival", 1'b1, n < 3000)
  endtask : wait_frames
  // ==========
  // Scenarios
  // ==========
  task automatic t_codes();
    int lv[7] = '{32768, 32769, 32767, 0, 65535, -5, 70000};
    int f0, f1;
    for (int i = 0; i < 7; i++) begin
      lvl0 <= lv[i];
      lvl1 <= lv[6-i];
      f0 = frames0;
      f1 = frames1;
      pulse(2'b11);
      wait_frames(f0 + 1, f1 + 1);
      `CHK("word0", code_of(lv[i]), word0)
      `CHK("word1", code_of(lv[6-i]), word1)
    end
  endtask : t_codes
  task automatic t_retrigger();
    int d0, f0;
    d0 = n_done0;
    f0 = frames0;
    lvl0 <= 12345;
    pulse(2'b01);
    repeat (6) @(posedge ref_clk);
    pulse(2'b01);
    wait_frames(f0 + 1, frames1);
    repeat (40) @(posedge ref_clk);
    `CHK("done count", d0 + 1, n_done0)
    `CHK("retrigger word", code_of(12345), word0)
  endtask : t_retrigger
  task automatic t_fill();
    int d0, d1, f0, n;
    d0 = n_done0;
    d1 = n_done1;
    f0 = frames0;
    hold0 <= 1'b1;
    for (int k = 0; k < DEPTH + 3; k++) begin
      lvl0 <= 100 + k;
      pulse(2'b01);
      repeat (20) @(posedge ref_clk);
    end
    n = n_done0 - d0;
    `CHK("fifo bound", DEPTH + 1, n)
    `CHK("other channel idle", d1, n_done1)
    hold0 <= 1'b0;
    wait_frames(f0 + n, frames1);
    `CHK("drained", n, frames0 - f0)
    `CHK("last word", code_of(100 + n - 1), word0)
  endtask : t_fill
  initial begin
    rst = 1'b1;
    cnv = 2'b00;
    hold0 = 1'b0;
    hold1 = 1'b0;
    lvl0 = 0;
    lvl1 = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_codes();
    t_retrigger();
    t_fill();
    summarize();
  end
endmodule : dual_sar_conversion_sequencer_tb
